// >>> rx_chain_model.sv
// Behavioural analog receive chain: noise, AGC comparator, pulses, strength.
// Assumes the gain code is window step plus stage reduction.
module rx_chain_model (
    // Clock and controls from the block
    input wire clk,
    input wire rx_on,
    input wire [2:0] digitizer_window,
    input wire [2:0] stage23_reduction,
    // Scenario knobs
    input wire [3:0] noise_limit,
    input wire [3:0] agc_limit,
    input wire [3:0] strength,
    // Comparators and strength levels
    output reg digitizer_out = 1'b0,
    output reg agc_comp_out = 1'b0,
    output reg subcarrier_pulse = 1'b0,
    output wire [3:0] rssi_level_am,
    output wire [3:0] rssi_level_pm
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Chain
    // ****************
    reg [7:0] cnt = 8'h00;
    wire [3:0] code = {1'b0, digitizer_window} + {1'b0, stage23_reduction};
    // Noise fades once the reduction reaches the knob, so loops can settle
    always @(posedge clk) begin
        cnt <= cnt + 8'h01;
        if (code < noise_limit && cnt[5:0] == 6'h00)
            digitizer_out <= ~digitizer_out;
        // Slow AGC toggles so eight pulses cannot finish the descent
        if (rx_on && code < agc_limit && cnt == 8'h00)
            agc_comp_out <= ~agc_comp_out;
        subcarrier_pulse <= rx_on && cnt[4];
    end
    assign rssi_level_am = strength;
    assign rssi_level_pm = strength - 4'h1;
endmodule // rx_chain_model

// >>> rx_gain_chk.sv
// Concurrent checks on the receiver gain block, seen from its ports.
// Assumes the constants of rx_gain_consts.vh and one clock domain.
`include "rx_gain_consts.vh"
module rx_gain_chk (
    // Clock, reset and bus
    input wire clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    // Receiver side
    input wire mask_timer_expired,
    input wire rx_on,
    input wire [2:0] digitizer_window,
    input wire [2:0] stage23_reduction,
    input wire [7:0] receiver_filter_config
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ****************
    // Shadow of mode
    // ****************
    reg [2:0] mode_seen;
    reg peer_seen;
    wire wr_ok = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    always @(posedge clk) begin
        if (rst) begin
            mode_seen <= 3'h0;
            peer_seen <= 1'b0;
        end else if (wr_ok && wb_adr_i == `ADDR_MODE_CONFIG) begin
            mode_seen <= wb_dat_i[2:0];
            peer_seen <= wb_dat_i[`PEER_GAIN_BIT];
        end
    end
    function automatic [7:0] preset_of(input [2:0] m);
        case (m)
            `MODE_B_128: preset_of = 8'h04;
            `MODE_32_16: preset_of = 8'h22;
            `MODE_PROP: preset_of = 8'h03;
            `MODE_8_4: preset_of = 8'h2c;
            `MODE_PEER: preset_of = 8'h05;
            default: preset_of = 8'h00;
        endcase
    endfunction
    sequence req_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence preset_cmd;
        wr_ok && wb_adr_i == `ADDR_COMMAND && wb_dat_i[2:0] == `CMD_PRESET;
    endsequence
    // ****************
    // Assertions
    // ****************
    a_ack_follows: assert property (req_taken |=> ack_pulse)
        else $error("ack missing or too long");
    a_window_range: assert property (digitizer_window <= 3'h4)
        else $error("window beyond fifth setting");
    a_reduction_range: assert property (stage23_reduction <= 3'h6)
        else $error("reduction beyond six steps");
    a_window_first: assert property (stage23_reduction != 3'h0 |-> digitizer_window == 3'h4)
        else $error("gain cut before window is widest");
    a_zero_combo: assert property (receiver_filter_config[2:1] != 2'b11)
        else $error("unused zero-select combination");
    a_timer_opens: assert property (mask_timer_expired |=> rx_on)
        else $error("window not opened by timer");
    a_preset_fields: assert property (preset_cmd |-> ##[0:2]
        receiver_filter_config == preset_of(mode_seen))
        else $error("preset filter fields wrong");
    a_peer_cut: assert property (peer_seen && !wb_cyc_i && !$past(wb_cyc_i) &&
        !$past(wb_cyc_i, 2) |-> digitizer_window == 3'h4 && stage23_reduction == 3'h2)
        else $error("peer gain cut not applied");
endmodule // rx_gain_chk

bind rx_gain_squelch_rssi_ctrl rx_gain_chk chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .mask_timer_expired(mask_timer_expired),
    .rx_on(rx_on), .digitizer_window(digitizer_window), .stage23_reduction(stage23_reduction),
    .receiver_filter_config(receiver_filter_config));

// >>> rx_gain_consts.vh
// Constants for the receiver gain, squelch and signal-strength block.
// Assumes a 25 MHz system clock and a classic Wishbone register port.
`ifndef RX_GAIN_CONSTS_VH
`define RX_GAIN_CONSTS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_FILTER_CONFIG 8'h00
`define ADDR_AGC_CONFIG 8'h04
`define ADDR_GAIN_CONFIG 8'h08
`define ADDR_MODE_CONFIG 8'h0c
`define ADDR_COMMAND 8'h10
`define ADDR_GAIN_DISPLAY 8'h14
`define ADDR_RSSI_DISPLAY 8'h18

// ****************************************
// Field positions and reset values
// ****************************************
`define AGC_EN_BIT 0
`define AGC_MODE_BIT 1
`define AGC_ALG_BIT 2
`define SQ_AUTO_BIT 3
`define AGC_CONFIG_RESET 8'h07
`define PEER_GAIN_BIT 4
`define CMD_PRESET 3'h0
`define CMD_RESET_GAIN 3'h1
`define CMD_SQUELCH 3'h2
`define CMD_CLEAR_RSSI 3'h3
`define CMD_MASK 3'h4
`define CMD_UNMASK 3'h5

// ****************************************
// Receive modes for the analog preset
// ****************************************
`define MODE_A_128 3'h0
`define MODE_B_128 3'h1
`define MODE_32_16 3'h2
`define MODE_PROP 3'h3
`define MODE_8_4 3'h4
`define MODE_PEER 3'h5

// ****************************************
// Gain state codes and counts
// ****************************************
`define GAIN_MAX_CODE 4'ha
`define GAIN_WINDOW_MAX 4'h4
`define GAIN_PEER_CODE 4'h6
`define RSSI_MAX_CODE 4'hd
`define SQ_TRANS_LIMIT 3'h2
`define AGC_PULSE_LIMIT 4'h8
`define CLK_HZ 25000000
`define SQ_INTERVAL_NS 50000
`define SQ_INTERVAL_CYC ((`SQ_INTERVAL_NS * (`CLK_HZ / 1000000)) / 1000)
`define SQ_DELAY_PS 18880000
`define SQ_DELAY_CYC (((`SQ_DELAY_PS * (`CLK_HZ / 1000000)) + 999999) / 1000000)

`endif

// >>> rx_gain_squelch_rssi_ctrl.v
// Receiver gain-reduction state, squelch, AGC and peak-hold signal strength.
// Assumes synchronous inputs and a Wishbone master on the same 25 MHz clock.
// Contract
// RL1 - Preset loads type A/B fc/128 filters
// RL2 - Preset loads other modes' filter fields
// RL3 - Only six zero-select combinations used
// RL4 - Five digitizer windows, 3 dB steps
// RL5 - Eleven shared gain-reduction codes
// RL6 - Loops start from configured code; displayed; code starts the AGC at window rise from code 4 or 0 instead
// RL7 - Capture gain at receive-window rise
// RL8 - Squelch steps while over two transitions
// RL9 - Reset gain command clears squelch reduction
// RL10 - Auto squelch after transmit until unmask; code ends it at mask timer expiry, reset gain, gain 10 or an interval of at most two transitions
// RL11 - Squelch command accepted only window low
// RL12 - AGC active while receive window high
// RL13 - AGC steps on its comparator transitions
// RL14 - Mode: whole window or eight pulses
// RL15 - Algorithm: preset code 4 or 0
// RL16 - Reset: AGC on, full window, preset
// RL17 - Signal strength peak hold, window high
// RL18 - Gain step clears signal strength; code clears it on AGC steps only, squelch steps leave it
// RL19 - Four-bit strength codes, maximum 13
// RL20 - Clear command zeroes strength results
// RL21 - Peer bit forces -6dB, window max
// RL22 - Controller disables AGC in anticollision
// RL23 - Window rises on mask timer expiry
// RL24 - Reset gain loads manual gain code
// RL25 - Stage gain 23 dB, six steps
// RL26 - Gain state saturates, never wraps
`include "rx_gain_consts.vh"

module rx_gain_squelch_rssi_ctrl (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Framing and timer events
    input wire tx_end,
    input wire mask_timer_expired,
    // Analog receiver comparators and strength levels
    input wire digitizer_out,
    input wire agc_comp_out,
    input wire subcarrier_pulse,
    input wire [3:0] rssi_level_am,
    input wire [3:0] rssi_level_pm,
    // Analog controls
    output reg rx_on,
    output reg [2:0] digitizer_window,
    output reg [2:0] stage23_reduction,
    output reg [7:0] receiver_filter_config
);

    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] agc_config;
    reg [3:0] gain_config;
    reg [7:0] mode_config;
    reg [3:0] gain_state;
    reg [3:0] gain_display;
    reg [3:0] rssi_am;
    reg [3:0] rssi_pm;
    reg sq_active;
    reg sq_wait;
    reg [8:0] sq_delay_cnt;
    reg [10:0] sq_int_cnt;
    reg [2:0] sq_trans;
    reg dig_q;
    reg agc_q;
    reg pulse_q;
    reg [3:0] pulse_cnt;
    reg [3:0] next_gain;
    reg [7:0] preset_val;
    reg gain_step;

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
    wire cmd_wr = wb_wr & (wb_adr_i == `ADDR_COMMAND);
    wire [2:0] cmd = wb_dat_i[2:0];
    wire do_preset = cmd_wr & (cmd == `CMD_PRESET);
    wire do_reset_gain = cmd_wr & (cmd == `CMD_RESET_GAIN);
    // RL11 window low only
    wire do_squelch = cmd_wr & (cmd == `CMD_SQUELCH) & ~rx_on;
    wire do_clear_rssi = cmd_wr & (cmd == `CMD_CLEAR_RSSI);
    wire do_mask = cmd_wr & (cmd == `CMD_MASK);
    wire do_unmask = cmd_wr & (cmd == `CMD_UNMASK);
    // RL23 window rise sources
    wire rx_on_set = mask_timer_expired | do_unmask;
    wire rx_rise = rx_on_set & ~rx_on;
    wire dig_edge = digitizer_out ^ dig_q;
    wire agc_edge = agc_comp_out ^ agc_q;
    wire pulse_rise = subcarrier_pulse & ~pulse_q;
    wire peer_cut = mode_config[`PEER_GAIN_BIT];
    wire sq_end = (sq_int_cnt == `SQ_INTERVAL_CYC - 1);
    // RL14 eight pulses or whole window
    wire agc_window = agc_config[`AGC_MODE_BIT] | (pulse_cnt < `AGC_PULSE_LIMIT);
    // RL13 step on own comparator
    wire agc_step = rx_on & agc_config[`AGC_EN_BIT] & agc_window & agc_edge;
    // RL8 more than two transitions
    wire sq_step = sq_active & sq_end & (sq_trans > `SQ_TRANS_LIMIT);

    // ****************************************
    // Analog preset lookup
    // ****************************************
    always @* begin
        case (mode_config[2:0])
            // RL1 type A and B
            `MODE_A_128: preset_val = 8'h00;
            `MODE_B_128: preset_val = 8'h04;
            // RL2 other modes
            `MODE_32_16: preset_val = 8'h22;
            `MODE_PROP: preset_val = 8'h03;
            `MODE_8_4: preset_val = 8'h2c;
            `MODE_PEER: preset_val = 8'h05;
            default: preset_val = receiver_filter_config;
        endcase
    end

    // ****************************************
    // Next gain state
    // ****************************************
    always @* begin
        next_gain = gain_state;
        gain_step = 1'b0;
        if (do_reset_gain) begin
            // RL24 manual code loaded
            next_gain = gain_config;
        end else if (rx_rise & agc_config[`AGC_EN_BIT]) begin
            // RL15 start algorithm
            next_gain = agc_config[`AGC_ALG_BIT] ? `GAIN_WINDOW_MAX : 4'h0;
        end else if ((agc_step | sq_step) & (gain_state < `GAIN_MAX_CODE)) begin
            // RL26 saturate at top
            next_gain = gain_state + 4'h1;
            gain_step = agc_step;
        end
    end

    // ****************************************
    // Control and loops
    // ****************************************
    always @(posedge clk) begin
        if (rst) begin
            receiver_filter_config <= 8'h00;
            // RL16 AGC defaults
            agc_config <= `AGC_CONFIG_RESET;
            gain_config <= 4'h0;
            mode_config <= 8'h00;
            gain_state <= 4'h0;
            gain_display <= 4'h0;
            rssi_am <= 4'h0;
            rssi_pm <= 4'h0;
            rx_on <= 1'b0;
            sq_active <= 1'b0;
            sq_wait <= 1'b0;
            sq_delay_cnt <= 9'h000;
            sq_int_cnt <= 11'h000;
            sq_trans <= 3'h0;
            dig_q <= 1'b0;
            agc_q <= 1'b0;
            pulse_q <= 1'b0;
            pulse_cnt <= 4'h0;
        end else begin
            dig_q <= digitizer_out;
            agc_q <= agc_comp_out;
            pulse_q <= subcarrier_pulse;
            if (wb_wr & (wb_adr_i == `ADDR_FILTER_CONFIG)) begin
                // RL3 unused combos left to software
                receiver_filter_config <= wb_dat_i[7:0];
            end else if (do_preset) begin
                receiver_filter_config <= preset_val;
            end
            if (wb_wr & (wb_adr_i == `ADDR_AGC_CONFIG)) begin
                agc_config <= {4'h0, wb_dat_i[3:0]};
            end
            if (wb_wr & (wb_adr_i == `ADDR_GAIN_CONFIG)) begin
                gain_config <= (wb_dat_i[3:0] > `GAIN_MAX_CODE) ? `GAIN_MAX_CODE : wb_dat_i[3:0];
            end
            if (wb_wr & (wb_adr_i == `ADDR_MODE_CONFIG)) begin
                mode_config <= {3'h0, wb_dat_i[4:0]};
            end
            // RL12 window high starts AGC
            if (rx_on_set) begin
                rx_on <= 1'b1;
            end else if (do_mask) begin
                rx_on <= 1'b0;
            end
            // RL5 shared state, RL9 reset clears squelch
            gain_state <= next_gain;
            // RL7 capture at rise
            if (rx_rise) begin
                gain_display <= gain_state;
            end
            // RL14 count pulses in window
            if (~rx_on) begin
                pulse_cnt <= 4'h0;
            end else if (pulse_rise & (pulse_cnt < `AGC_PULSE_LIMIT)) begin
                pulse_cnt <= pulse_cnt + 4'h1;
            end
            // RL10 auto squelch timing
            if (tx_end & agc_config[`SQ_AUTO_BIT]) begin
                sq_wait <= 1'b1;
                sq_delay_cnt <= 9'h000;
            end else if (sq_wait) begin
                if (sq_delay_cnt == `SQ_DELAY_CYC - 1) begin
                    sq_wait <= 1'b0;
                end
                sq_delay_cnt <= sq_delay_cnt + 9'h001;
            end
            if (mask_timer_expired | do_reset_gain) begin
                sq_active <= 1'b0;
                sq_wait <= 1'b0;
            end else if (do_squelch | (sq_wait & (sq_delay_cnt == `SQ_DELAY_CYC - 1))) begin
                sq_active <= 1'b1;
                sq_int_cnt <= 11'h000;
                sq_trans <= 3'h0;
            end else if (sq_active) begin
                // RL8 interval counting
                if (sq_end) begin
                    sq_int_cnt <= 11'h000;
                    sq_trans <= 3'h0;
                    if ((sq_trans <= `SQ_TRANS_LIMIT) | (gain_state == `GAIN_MAX_CODE)) begin
                        sq_active <= 1'b0;
                    end
                end else begin
                    sq_int_cnt <= sq_int_cnt + 11'h001;
                    if (dig_edge & (sq_trans != 3'h7)) begin
                        sq_trans <= sq_trans + 3'h1;
                    end
                end
            end
            // RL18 RL20 clear strength
            if (gain_step | do_clear_rssi | do_reset_gain | rx_rise) begin
                rssi_am <= 4'h0;
                rssi_pm <= 4'h0;
            end else if (rx_on) begin
                // RL17 RL19 peak hold capped
                if ((rssi_level_am > rssi_am) & (rssi_level_am <= `RSSI_MAX_CODE)) begin
                    rssi_am <= rssi_level_am;
                end
                if ((rssi_level_pm > rssi_pm) & (rssi_level_pm <= `RSSI_MAX_CODE)) begin
                    rssi_pm <= rssi_level_pm;
                end
            end
        end
    end

    // ****************************************
    // Analog outputs
    // ****************************************
    always @(posedge clk) begin
        if (rst) begin
            digitizer_window <= 3'h0;
            stage23_reduction <= 3'h0;
        end else if (peer_cut) begin
            // RL21 forced -6dB, window max
            digitizer_window <= 3'h4;
            stage23_reduction <= 3'h2;
        end else if (next_gain > `GAIN_WINDOW_MAX) begin
            // RL25 six 3 dB steps
            digitizer_window <= 3'h4;
            stage23_reduction <= next_gain[2:0] - 3'h4;
        end else begin
            // RL4 five window settings
            digitizer_window <= next_gain[2:0];
            stage23_reduction <= 3'h0;
        end
    end

    // ****************************************
    // Wishbone slave, one registered ack a cycle after request
    // ****************************************
    always @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req & ~wb_we_i) begin
                case (wb_adr_i)
                    `ADDR_FILTER_CONFIG: wb_dat_o <= {24'h000000, receiver_filter_config};
                    `ADDR_AGC_CONFIG: wb_dat_o <= {24'h000000, agc_config};
                    `ADDR_GAIN_CONFIG: wb_dat_o <= {28'h0000000, gain_config};
                    `ADDR_MODE_CONFIG: wb_dat_o <= {24'h000000, mode_config};
                    // RL6 actual state display
                    `ADDR_GAIN_DISPLAY: wb_dat_o <= {24'h000000, gain_state, gain_display};
                    `ADDR_RSSI_DISPLAY: wb_dat_o <= {24'h000000, rssi_pm, rssi_am};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // rx_gain_squelch_rssi_ctrl

// >>> tb.sv
// Self-checking bench for the receiver gain block with an analog chain model.
// Assumes the constants of rx_gain_consts.vh and a 25 MHz clock.
`include "rx_gain_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, tx_end = 0, tmr = 0;
    reg [7:0] adr = 8'h00, f;
    reg [3:0] sel = 4'h0, noise = 4'h0, agcl = 4'h0, sig = 4'h9, g;
    reg [31:0] dat = 32'h0, q, seed = 32'h0000_1230;
    wire [31:0] dat_o;
    wire ack, rx_on, dig, agcc, pulse;
    wire [2:0] win, red;
    wire [3:0] am, pm;
    wire [7:0] filt;
    int mismatches = 0, n_checks = 0, i;
    // Presets in mode order: A, B, fc/32-16, proprietary, fc/8-4, peer
    reg [7:0] pre [0:5] = '{8'h00, 8'h04, 8'h22, 8'h03, 8'h2c, 8'h05};
    reg [2:0] zs [0:5] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h3, 3'h5};
    reg [2:0] lps [0:4] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
    reg [7:0] ra [0:6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c};
    rx_gain_squelch_rssi_ctrl dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .tx_end(tx_end), .mask_timer_expired(tmr), .digitizer_out(dig),
        .agc_comp_out(agcc), .subcarrier_pulse(pulse), .rssi_level_am(am),
        .rssi_level_pm(pm), .rx_on(rx_on), .digitizer_window(win), .stage23_reduction(red),
        .receiver_filter_config(filt));
    rx_chain_model ana (.clk(clk), .rx_on(rx_on), .digitizer_window(win),
        .stage23_reduction(red), .noise_limit(noise), .agc_limit(agcl), .strength(sig),
        .digitizer_out(dig), .agc_comp_out(agcc), .subcarrier_pulse(pulse),
        .rssi_level_am(am), .rssi_level_pm(pm));
    // ****************
    // Helpers
    // ****************
    initial begin
        forever #20 clk = ~clk;
    end
    function automatic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic [5:0] outs(input [3:0] c);
        outs = c > 4'h4 ? {3'h4, 3'(c - 4'h4)} : {c[2:0], 3'h0};
    endfunction
    task automatic chk(input string what, input [31:0] exp, input [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input w, input [7:0] a, input [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        if (n >= 20) chk("ack", 32'h1, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask
    task automatic cmd(input [2:0] c);
        bus(1'b1, `ADDR_COMMAND, {29'h0, c});
    endtask
    task automatic end_sim();
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        idle(90000);
        mismatches++;
        end_sim();
    end
    // ****************
    // Scenarios
    // ****************
    initial begin
        idle(4);
        rst <= 1'b0;
        for (i = 0; i < 7; i++) rd(ra[i], i == 1 ? 32'(`AGC_CONFIG_RESET) : 32'h0, "reset");
        bus(1'b1, `ADDR_GAIN_DISPLAY, 32'hff);
        rd(`ADDR_GAIN_DISPLAY, 32'h0, "read-only display");
        bus(1'b1, `ADDR_AGC_CONFIG, 32'h0);
        for (i = 0; i < 6; i++) begin
            bus(1'b1, `ADDR_MODE_CONFIG, 32'(i));
            cmd(`CMD_PRESET);
            rd(`ADDR_FILTER_CONFIG, {24'h0, pre[i]}, "preset filter");
        end
        for (i = 0; i < 6; i++) begin
            f = {2'b0, lps[rnd() % 5], zs[rnd() % 6]};
            g = 4'(rnd() % 11);
            bus(1'b1, `ADDR_FILTER_CONFIG, {24'h0, f});
            rd(`ADDR_FILTER_CONFIG, {24'h0, f}, "filter word");
            bus(1'b1, `ADDR_GAIN_CONFIG, {28'h0, g});
            cmd(`CMD_RESET_GAIN);
            rd(`ADDR_GAIN_DISPLAY, {24'h0, g, 4'h0}, "manual gain");
            chk("gain outputs", {26'h0, outs(g)}, {26'h0, win, red});
        end
        bus(1'b1, `ADDR_GAIN_CONFIG, 32'h3);
        cmd(`CMD_RESET_GAIN);
        noise <= 4'h7;
        cmd(`CMD_SQUELCH);
        idle(10000);
        rd(`ADDR_GAIN_DISPLAY, 32'h70, "squelch stop");
        chk("squelch outputs", {26'h0, outs(4'h7)}, {26'h0, win, red});
        cmd(`CMD_RESET_GAIN);
        rd(`ADDR_GAIN_DISPLAY, 32'h30, "gain reset");
        noise <= 4'hf;
        cmd(`CMD_SQUELCH);
        idle(12500);
        rd(`ADDR_GAIN_DISPLAY, 32'ha0, "squelch ceiling");
        cmd(`CMD_RESET_GAIN);
        cmd(`CMD_UNMASK);
        cmd(`CMD_SQUELCH);
        idle(3750);
        rd(`ADDR_GAIN_DISPLAY, 32'h33, "squelch in window");
        bus(1'b1, `ADDR_AGC_CONFIG, 32'h8);
        cmd(`CMD_MASK);
        cmd(`CMD_RESET_GAIN);
        tx_end <= 1'b1;
        @(posedge clk);
        tx_end <= 1'b0;
        idle(3572);
        tmr <= 1'b1;
        @(posedge clk);
        tmr <= 1'b0;
        idle(2500);
        rd(`ADDR_GAIN_DISPLAY, 32'h55, "auto squelch");
        noise <= 4'h0;
        sig <= 4'hc;
        bus(1'b1, `ADDR_GAIN_CONFIG, 32'h2);
        cmd(`CMD_MASK);
        cmd(`CMD_RESET_GAIN);
        bus(1'b1, `ADDR_AGC_CONFIG, 32'(`AGC_CONFIG_RESET));
        cmd(`CMD_UNMASK);
        rd(`ADDR_GAIN_DISPLAY, 32'h42, "agc preset start");
        agcl <= 4'h7;
        idle(480);
        sig <= 4'h9;
        idle(1300);
        rd(`ADDR_GAIN_DISPLAY, 32'h72, "agc steps");
        rd(`ADDR_RSSI_DISPLAY, 32'h89, "rssi restart");
        cmd(`CMD_MASK);
        sig <= 4'hc;
        idle(20);
        rd(`ADDR_RSSI_DISPLAY, 32'h89, "rssi frozen");
        cmd(`CMD_CLEAR_RSSI);
        rd(`ADDR_RSSI_DISPLAY, 32'h0, "rssi cleared");
        agcl <= 4'h0;
        bus(1'b1, `ADDR_AGC_CONFIG, 32'h3);
        cmd(`CMD_UNMASK);
        bus(1'b0, `ADDR_GAIN_DISPLAY, 32'h0);
        chk("agc zero start", 32'h0, {28'h0, q[7:4]});
        bus(1'b1, `ADDR_MODE_CONFIG, 32'h15);
        idle(3);
        chk("peer cut", 32'h42, {24'h0, 1'b0, win, 1'b0, red});
        bus(1'b1, 8'h1c, 32'hff);
        rd(8'h1c, 32'h0, "unmapped");
        end_sim();
    end
endmodule // tb
